// File: ulss_line_status.sv
// line status word, spare byte, receive buffer and event interrupt on apb
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ulss_line_status #(
  parameter int OVERSAMPLE = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        sample_tick,
  input  wire logic [1:0]  word_len,
  input  wire logic        parity_en,
  input  wire logic [1:0]  parity_select_field,
  input  wire logic        tx_hold_load,
  input  wire logic        tx_hold_to_shift,
  input  wire logic        tx_shift_busy,
  input  wire logic        tx_hold_empty_int_en,
  output logic             tx_hold_empty_irq_req,
  output logic [2:0]       int_id,
  output logic             irq
);
  import ulss_pkg::*;

  logic                 rxd_meta_reg;      // first synchroniser stage
  logic                 rxd_sync_reg;      // usable line level
  logic [31:0]          prdata_reg;        // read data captured in setup
  logic                 data_ready_reg;    // character waiting
  logic                 overrun_reg;       // sticky overrun
  logic                 parity_error_reg;  // sticky parity error
  logic                 framing_error_reg; // sticky framing error
  logic                 break_flag_reg;    // sticky break
  logic                 tx_hold_empty_reg; // holding register empty
  logic                 tx_all_empty_reg;  // holding and shifter empty
  logic [7:0]           rx_buffer_reg;     // last received character
  logic [7:0]           spare_byte_reg;    // software scratch byte
  logic [EVT_WIDTH-1:0] evt_status_reg;    // sticky events
  logic [EVT_WIDTH-1:0] evt_mask_reg;      // event enables
  logic [2:0]           int_id_reg;        // registered identification
  logic [31:0]          line_status_word;
  logic [31:0]          rd_value;
  logic                 addr_hit;
  logic                 apb_setup;
  logic                 apb_access;
  logic                 rd_lsw;
  logic                 rd_rbr;
  logic                 wr_spare;
  logic                 wr_evt_status;
  logic                 wr_evt_mask;
  logic                 rx_done;
  logic [7:0]           rx_data;
  logic                 rx_parity_err;
  logic                 rx_frame_err;
  logic                 rx_break;
  logic                 ev_overrun;
  logic                 ev_parity;
  logic                 ev_framing;
  logic                 line_err_any;
  logic [EVT_WIDTH-1:0] evt_set;

  // the serial pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  // receiver proper
  ulss_rx_core #(.OVERSAMPLE(OVERSAMPLE)) u_rx (
    .pclk                (pclk),
    .presetn             (presetn),
    .sample_tick         (sample_tick),
    .rxd                 (rxd_sync_reg),
    .word_len            (word_len),
    .parity_en           (parity_en),
    .parity_select_field (parity_select_field),
    .rx_done             (rx_done),
    .rx_data             (rx_data),
    .rx_parity_err       (rx_parity_err),
    .rx_frame_err        (rx_frame_err),
    .rx_break            (rx_break)
  );

  // bus phase decode; the slave never waits
  assign apb_setup     = psel && !penable;
  assign apb_access    = psel && penable;
  assign pready        = 1'b1;
  assign pslverr       = apb_access && !addr_hit;
  assign prdata        = prdata_reg;
  assign rd_lsw        = apb_access && !pwrite && (paddr == ADDR_LINE_STATUS);
  assign rd_rbr        = apb_access && !pwrite && (paddr == ADDR_RX_BUFFER);
  assign wr_spare      = apb_access && pwrite && (paddr == ADDR_SPARE);
  assign wr_evt_status = apb_access && pwrite && (paddr == ADDR_EVT_STATUS);
  assign wr_evt_mask   = apb_access && pwrite && (paddr == ADDR_EVT_MASK);

  // status word, upper bits tied low
  assign line_status_word = {25'h0000000, tx_all_empty_reg, tx_hold_empty_reg, break_flag_reg,
                             framing_error_reg, parity_error_reg, overrun_reg, data_ready_reg};

  // read mux and address decode
  always_comb begin
    rd_value = 32'h00000000;
    addr_hit = 1'b1;
    unique case (paddr)
      ADDR_RX_BUFFER:   rd_value = {24'h000000, rx_buffer_reg};
      ADDR_LINE_STATUS: rd_value = line_status_word;
      ADDR_SPARE:       rd_value = {24'h000000, spare_byte_reg};
      ADDR_EVT_STATUS:  rd_value = {29'h00000000, evt_status_reg};
      ADDR_EVT_MASK:    rd_value = {29'h00000000, evt_mask_reg};
      default:          addr_hit = 1'b0; // unmapped reads zero with error
    endcase
  end

  // read data registered in setup so the access phase sees a stable word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_reg <= 32'h00000000;
    else if (apb_setup && !pwrite) prdata_reg <= rd_value;
  end

  // receive buffer and data ready; a new character wins over the buffer read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buffer_reg  <= 8'h00;
      data_ready_reg <= 1'b0;
    end else begin
      if (rx_done) rx_buffer_reg <= rx_data;
      if (rx_done) data_ready_reg <= 1'b1;
      else if (rd_rbr) data_ready_reg <= 1'b0;
    end
  end

  // error events from the receiver
  assign ev_overrun = rx_done && data_ready_reg && !rd_rbr;
  assign ev_parity  = rx_done && rx_parity_err;
  assign ev_framing = rx_done && rx_frame_err;

  // sticky errors: only bits the read actually returned are cleared,
  // so an event landing between setup and access is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_reg       <= 1'b0;
      parity_error_reg  <= 1'b0;
      framing_error_reg <= 1'b0;
      break_flag_reg    <= 1'b0;
    end else begin
      overrun_reg       <= (overrun_reg && !(rd_lsw && prdata_reg[LSW_OVERRUN])) || ev_overrun;
      parity_error_reg  <= (parity_error_reg && !(rd_lsw && prdata_reg[LSW_PARITY])) || ev_parity;
      framing_error_reg <= (framing_error_reg && !(rd_lsw && prdata_reg[LSW_FRAMING])) || ev_framing;
      break_flag_reg    <= (break_flag_reg && !(rd_lsw && prdata_reg[LSW_BREAK])) || rx_break;
    end
  end

  // transmitter flags; a load in the same cycle as a move leaves it full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_empty_reg <= 1'b1;
      tx_all_empty_reg  <= 1'b1;
    end else begin
      if (tx_hold_load) tx_hold_empty_reg <= 1'b0;
      else if (tx_hold_to_shift) tx_hold_empty_reg <= 1'b1;
      tx_all_empty_reg <= !tx_hold_load && (tx_hold_empty_reg || tx_hold_to_shift) && !tx_shift_busy;
    end
  end
  assign tx_hold_empty_irq_req = tx_hold_empty_reg && tx_hold_empty_int_en;

  // spare byte steers nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spare_byte_reg <= SPARE_RESET;
    else if (wr_spare) spare_byte_reg <= pwdata[7:0]; // upper write bits dropped
  end

  // event status, write one to clear, set wins
  assign line_err_any = overrun_reg || parity_error_reg || framing_error_reg || break_flag_reg;
  assign evt_set[EVT_DATA] = rx_done;
  assign evt_set[EVT_LINE] = ev_overrun || ev_parity || ev_framing || rx_break;
  assign evt_set[EVT_TX_HOLD_EMPTY] = tx_hold_to_shift && !tx_hold_load;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_reg <= EVT_RESET;
      evt_mask_reg   <= EVT_RESET;
    end else begin
      evt_status_reg <= (evt_status_reg & ~({EVT_WIDTH{wr_evt_status}} & pwdata[EVT_WIDTH-1:0])) | evt_set;
      if (wr_evt_mask) evt_mask_reg <= pwdata[EVT_WIDTH-1:0];
    end
  end
  assign irq = |(evt_status_reg & evt_mask_reg);

  // identification, line errors first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_id_reg <= INT_ID_NONE;
    else if (line_err_any) int_id_reg <= INT_ID_LINE;
    else if (data_ready_reg) int_id_reg <= INT_ID_DATA;
    else if (tx_hold_empty_irq_req) int_id_reg <= INT_ID_TX_HOLD_EMPTY;
    else int_id_reg <= INT_ID_NONE;
  end
  assign int_id = int_id_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_lsw_upper_zero: assert property (rd_lsw |-> prdata[31:LSW_WIDTH] == 25'h0000000)
    else $error("status word upper bits not zero");
  chk_all_empty_load: assert property (tx_hold_load |=> !line_status_word[LSW_ALL_EMPTY])
    else $error("all-empty set while holding loaded");
  chk_hold_load_move: assert property (tx_hold_load |=> !tx_hold_empty_reg ##1
    (tx_hold_empty_reg == $past(tx_hold_to_shift) || $past(tx_hold_load)))
    else $error("holding empty flag wrong");
  chk_tx_hold_empty_request: assert property (tx_hold_to_shift && !tx_hold_load && tx_hold_empty_int_en |=> tx_hold_empty_irq_req)
    else $error("no transmit request when empty");
  chk_break_set: assert property (rx_break |=> break_flag_reg [*2])
    else $error("break flag not held");
  chk_framing_set: assert property (ev_framing |=> framing_error_reg)
    else $error("framing error not flagged");
  chk_parity_set: assert property (ev_parity |=> parity_error_reg ##0 line_status_word[LSW_PARITY])
    else $error("parity error not flagged");
  chk_overrun_set: assert property (rx_done && data_ready_reg && !rd_rbr |=> overrun_reg)
    else $error("overrun not flagged");
  chk_ready_clear: assert property (rd_rbr && !rx_done |=> !data_ready_reg)
    else $error("data ready not cleared by buffer read");
  chk_spare_store: assert property (wr_spare |=> spare_byte_reg == $past(pwdata[7:0]))
    else $error("spare byte not stored");
  chk_line_id: assert property (line_err_any |=> int_id == INT_ID_LINE)
    else $error("line status id not first");
  chk_read_clear: assert property (rd_lsw && prdata_reg[LSW_FRAMING] && !ev_framing |=> !framing_error_reg)
    else $error("read did not clear framing error");
  chk_set_wins: assert property (rd_lsw && (ev_framing || rx_break) |=>
    (framing_error_reg || break_flag_reg))
    else $error("new error lost to clearing read");

  cov_char_rx: cover property (rx_done ##[1:1000] rd_rbr);
  cov_frame_err: cover property (ev_framing ##[1:1000] rd_lsw);
  cov_break: cover property (rx_break);
  cov_irq: cover property ($rose(irq));
endmodule : ulss_line_status
`default_nettype wire

// File: ulss_pkg.sv
// shared constants and types for the line status and spare byte block
package ulss_pkg;
  // register byte offsets on the peripheral bus
  localparam logic [7:0] ADDR_RX_BUFFER   = 8'h00;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;
  localparam logic [7:0] ADDR_SPARE       = 8'h1C;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'h24;
  // line status word bit positions
  localparam int LSW_DATA_READY = 0;
  localparam int LSW_OVERRUN    = 1;
  localparam int LSW_PARITY     = 2;
  localparam int LSW_FRAMING    = 3;
  localparam int LSW_BREAK      = 4;
  localparam int LSW_HOLD_EMPTY = 5;
  localparam int LSW_ALL_EMPTY  = 6;
  localparam int LSW_WIDTH      = 7;
  // reset values
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET   = 3'h0;
  // event status and mask bit positions
  localparam int EVT_DATA  = 0;
  localparam int EVT_LINE  = 1;
  localparam int EVT_TX_HOLD_EMPTY  = 2;
  localparam int EVT_WIDTH = 3;
  // interrupt identification codes
  localparam logic [2:0] INT_ID_LINE = 3'h6;
  localparam logic [2:0] INT_ID_DATA = 3'h4;
  localparam logic [2:0] INT_ID_TX_HOLD_EMPTY = 3'h2;
  localparam logic [2:0] INT_ID_NONE = 3'h1;
  // parity select encodings
  localparam logic [1:0] PAR_ODD  = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ONE  = 2'h2;
  localparam logic [1:0] PAR_ZERO = 2'h3;
  // high samples needed before the receiver re-arms after a framing error
  localparam logic [1:0] RESYNC_HIGH_SAMPLES = 2'h2;
  // receiver states
  typedef enum logic [5:0] {
    RX_IDLE   = 6'h01,
    RX_START  = 6'h02,
    RX_DATA   = 6'h04,
    RX_PARITY = 6'h08,
    RX_STOP   = 6'h10,
    RX_RESYNC = 6'h20
  } ulss_rx_state_t;
endpackage : ulss_pkg

// File: ulss_rx_core.sv
// oversampling character receiver with parity, framing and break detection
`timescale 1ns/1ps
`default_nettype none
module ulss_rx_core #(
  parameter int OVERSAMPLE = 16
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sample_tick,
  input  wire logic       rxd,
  input  wire logic [1:0] word_len,
  input  wire logic       parity_en,
  input  wire logic [1:0] parity_select_field,
  output logic            rx_done,
  output logic [7:0]      rx_data,
  output logic            rx_parity_err,
  output logic            rx_frame_err,
  output logic            rx_break
);
  import ulss_pkg::*;
  localparam int CW = $clog2(OVERSAMPLE);
  localparam logic [CW-1:0] MID  = CW'(OVERSAMPLE / 2 - 1);
  localparam logic [CW-1:0] LAST = CW'(OVERSAMPLE - 1);

  ulss_rx_state_t  state_reg;     // receiver sequence
  logic [CW-1:0]   tick_cnt_reg;  // ticks inside current bit
  logic [2:0]      bit_cnt_reg;   // data bits taken
  logic [7:0]      shift_reg;     // lsb first
  logic [1:0]      high_cnt_reg;  // consecutive high samples in resync
  logic [11:0]     low_cnt_reg;   // consecutive low samples
  logic            brk_armed_reg; // one break report per low stretch
  logic            bit_end;
  logic            last_bit;
  logic [7:0]      data_aligned;
  logic            par_bad;
  logic [11:0]     frame_ticks;

  assign bit_end      = sample_tick && (tick_cnt_reg == LAST);
  assign last_bit     = bit_cnt_reg == (3'h4 + {1'b0, word_len});
  assign data_aligned = shift_reg >> (3'h3 - {1'b0, word_len});
  // whole frame: start, data, optional parity, one stop
  assign frame_ticks  = (12'h007 + {10'h000, word_len} + {11'h000, parity_en}) * 12'(OVERSAMPLE);

  // parity check per select field
  always_comb begin
    unique case (parity_select_field)
      PAR_ODD:  par_bad = ~(^data_aligned ^ rxd);
      PAR_EVEN: par_bad = ^data_aligned ^ rxd;
      PAR_ONE:  par_bad = ~rxd;
      PAR_ZERO: par_bad = rxd;
    endcase
  end

  // character sequencer; parity verdict is latched at the parity sample
  logic par_bad_reg;  // parity verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= RX_IDLE;
      tick_cnt_reg  <= '0;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      high_cnt_reg  <= 2'h0;
      par_bad_reg   <= 1'b0;
      rx_done       <= 1'b0;
      rx_data       <= 8'h00;
      rx_parity_err <= 1'b0;
      rx_frame_err  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (state_reg)
        RX_IDLE: if (sample_tick && !rxd) begin
          state_reg    <= RX_START;
          tick_cnt_reg <= '0;
        end
        // start bit is sampled twice at mid bit
        RX_START: if (sample_tick) begin
          tick_cnt_reg <= tick_cnt_reg + 1'b1;
          if ((tick_cnt_reg == MID || tick_cnt_reg == MID + 1'b1) && rxd) begin
            state_reg <= RX_IDLE; // glitch, not a start
          end else if (tick_cnt_reg == MID + 1'b1) begin
            state_reg    <= RX_DATA;
            tick_cnt_reg <= '0;
            bit_cnt_reg  <= 3'h0;
            par_bad_reg  <= 1'b0;
          end
        end
        RX_DATA: if (sample_tick) begin
          tick_cnt_reg <= tick_cnt_reg + 1'b1;
          if (bit_end) begin
            shift_reg   <= {rxd, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (last_bit) begin
              state_reg <= parity_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: if (sample_tick) begin
          tick_cnt_reg <= tick_cnt_reg + 1'b1;
          if (bit_end) begin
            par_bad_reg <= par_bad;
            state_reg   <= RX_STOP;
          end
        end
        RX_STOP: if (sample_tick) begin
          tick_cnt_reg <= tick_cnt_reg + 1'b1;
          if (bit_end) begin
            rx_done       <= 1'b1;
            rx_data       <= data_aligned;
            rx_parity_err <= parity_en && par_bad_reg;
            rx_frame_err  <= !rxd;
            high_cnt_reg  <= 2'h0;
            state_reg     <= rxd ? RX_IDLE : RX_RESYNC;
          end
        end
        // wait for marking line before hunting the next start
        RX_RESYNC: if (sample_tick) begin
          high_cnt_reg <= rxd ? high_cnt_reg + 1'b1 : 2'h0;
          if (rxd && high_cnt_reg == RESYNC_HIGH_SAMPLES - 1'b1) begin
            state_reg <= RX_IDLE;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  // break: line low for longer than a whole frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg   <= 12'h000;
      brk_armed_reg <= 1'b1;
      rx_break      <= 1'b0;
    end else begin
      rx_break <= sample_tick && !rxd && brk_armed_reg && (low_cnt_reg == frame_ticks);
      if (sample_tick) begin
        if (rxd) begin
          low_cnt_reg   <= 12'h000;
          brk_armed_reg <= 1'b1;
        end else begin
          if (low_cnt_reg != 12'hFFF) low_cnt_reg <= low_cnt_reg + 12'h001;
          if (low_cnt_reg == frame_ticks) brk_armed_reg <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_start_twice: assert property ((state_reg == RX_START) && sample_tick && rxd &&
    (tick_cnt_reg == MID || tick_cnt_reg == MID + 1'b1) |=> state_reg == RX_IDLE)
    else $error("start bit not sampled twice");
  chk_resync_entry: assert property ((state_reg == RX_STOP) && bit_end && !rxd |=>
    state_reg == RX_RESYNC ##0 rx_frame_err)
    else $error("no resync after framing error");
endmodule : ulss_rx_core
`default_nettype wire

// File: ulss_serial_partner.sv
// remote serial transmitter model with its baud tick source
`timescale 1ns/1ps
`default_nettype none
module ulss_serial_partner #(
  parameter int OVERSAMPLE = 16
) (
  input  wire logic pclk,
  output logic      rxd,
  output logic      sample_tick
);
  logic tick_reg = 1'b0; // one tick every two clocks
  initial rxd = 1'b1;    // line idles in the marking state
  // free running tick, like the real baud generator
  always @(posedge pclk) begin
    tick_reg <= ~tick_reg;
  end
  assign sample_tick = tick_reg;
  // hold the line at a level for a number of bit times
  task automatic hold(input logic v, input int n);
    @(posedge pclk);
    rxd <= v;
    repeat (n * 2 * OVERSAMPLE - 1) @(posedge pclk);
  endtask : hold
  // one character, lsb first, then a two bit idle gap
  task automatic send(input logic [7:0] v, input int nb, input logic pen, input logic pbit, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++) hold(v[i], 1);
    if (pen) hold(pbit, 1);
    hold(stop, 1);
    hold(1'b1, 2);
  endtask : send
endmodule : ulss_serial_partner
`default_nettype wire

// File: uart_line_status_scratch_bench.sv
// self-checking bench for the line status and spare byte block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_line_status_scratch_bench;
  import ulss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, sample_tick, p;
  logic        tx_hold_load, tx_hold_to_shift, tx_shift_busy, tx_hold_empty_int_en, tx_hold_empty_irq_req, irq, parity_en;
  logic [1:0]  word_len, parity_select_field;
  logic [2:0]  int_id;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];        // expected {pslverr, prdata} per read
  int          miscompares, n_tests, nb;
  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ulss_line_status #(.OVERSAMPLE(16)) ulss_line_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .sample_tick(sample_tick), .word_len(word_len), .parity_en(parity_en),
    .parity_select_field(parity_select_field), .tx_hold_load(tx_hold_load), .tx_hold_to_shift(tx_hold_to_shift),
    .tx_shift_busy(tx_shift_busy), .tx_hold_empty_int_en(tx_hold_empty_int_en), .tx_hold_empty_irq_req(tx_hold_empty_irq_req), .int_id(int_id), .irq(irq));
  ulss_serial_partner #(.OVERSAMPLE(16)) ulss_serial_partner_i (.pclk(pclk), .rxd(rxd), .sample_tick(sample_tick));
  // one apb transfer; starts on an edge, leaves one idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb
  // read with the expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // monitor: every completed read is matched to the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) `CHK({pslverr, prdata}, exp_q.pop_front())
  end
  // parity bit that the remote end must send
  function automatic logic exp_par(input logic [7:0] v, input logic [1:0] s);
    case (s)
      PAR_ODD:  return ~^v;
      PAR_EVEN: return ^v;
      PAR_ONE:  return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction : exp_par
  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // watchdog, well beyond the roughly five thousand cycles needed
  initial begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    test_done();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, tx_hold_load, tx_hold_to_shift, tx_shift_busy, tx_hold_empty_int_en, parity_en} = '0;
    {paddr, pwdata, word_len, parity_select_field, presetn} = '0;
    {miscompares, n_tests} = '0;
    void'($urandom(32'hEDA3AC1A));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_LINE_STATUS, 33'h60);
    rd(ADDR_SPARE, 33'h0);
    @(negedge pclk) `CHK(int_id, INT_ID_NONE)
    `CHK(pready, 1'b1)
    // spare byte round trips; upper bits written as zero
    repeat (3) begin
      d = 8'($urandom);
      apb(1'b1, ADDR_SPARE, {24'h0, d});
      rd(ADDR_SPARE, {25'h0, d});
    end
    rd(ADDR_LINE_STATUS, 33'h60);
    apb(1'b1, ADDR_LINE_STATUS, 32'hFFFFFFFF);
    rd(ADDR_LINE_STATUS, 33'h60);
    rd(8'h40, 33'h100000000);
    apb(1'b1, ADDR_EVT_MASK, 32'h7);
    // transmitter: load, move into shifter, drain
    @(posedge pclk) tx_hold_empty_int_en <= 1'b1;
    @(negedge pclk) `CHK(tx_hold_empty_irq_req, 1'b1)
    @(posedge pclk) tx_hold_load <= 1'b1;
    @(posedge pclk) tx_hold_load <= 1'b0;
    @(negedge pclk) `CHK(tx_hold_empty_irq_req, 1'b0)
    rd(ADDR_LINE_STATUS, 33'h00);
    @(posedge pclk) {tx_shift_busy, tx_hold_to_shift} <= 2'b11;
    @(posedge pclk) tx_hold_to_shift <= 1'b0;
    rd(ADDR_LINE_STATUS, 33'h20);
    @(negedge pclk) `CHK(irq, 1'b1)
    `CHK(int_id, INT_ID_TX_HOLD_EMPTY)
    apb(1'b1, ADDR_EVT_MASK, 32'h0);
    @(negedge pclk) `CHK(irq, 1'b0)
    apb(1'b1, ADDR_EVT_MASK, 32'h7);
    rd(ADDR_EVT_STATUS, 33'h4);
    apb(1'b1, ADDR_EVT_STATUS, 32'h4);
    @(negedge pclk) `CHK(irq, 1'b0)
    @(posedge pclk) {tx_shift_busy, tx_hold_empty_int_en} <= 2'b00;
    rd(ADDR_LINE_STATUS, 33'h60);
    // every parity mode, each paired with one word length, good then bad parity
    for (int s = 0; s < 4; s++) begin
      nb = 5 + s;
      @(posedge pclk) {parity_select_field, word_len, parity_en} <= {2'(s), 2'(s), 1'b1};
      d = 8'($urandom) & 8'((9'h1 << nb) - 9'h1);
      p = exp_par(d, 2'(s));
      ulss_serial_partner_i.send(d, nb, 1'b1, p, 1'b1);
      @(negedge pclk) `CHK(int_id, INT_ID_DATA)
      rd(ADDR_LINE_STATUS, 33'h61);
      rd(ADDR_RX_BUFFER, {25'h0, d});
      ulss_serial_partner_i.send(d, nb, 1'b1, ~p, 1'b1);
      @(negedge pclk) `CHK(int_id, INT_ID_LINE)
      rd(ADDR_LINE_STATUS, 33'h65);
      rd(ADDR_LINE_STATUS, 33'h61);
      rd(ADDR_RX_BUFFER, {25'h0, d});
    end
    // overrun: second character lands on an unread one
    @(posedge pclk) parity_en <= 1'b0;
    ulss_serial_partner_i.send(8'hA5, 8, 1'b0, 1'b0, 1'b1);
    ulss_serial_partner_i.send(8'h3C, 8, 1'b0, 1'b0, 1'b1);
    rd(ADDR_LINE_STATUS, 33'h63);
    rd(ADDR_RX_BUFFER, 33'h3C);
    rd(ADDR_LINE_STATUS, 33'h60);
    // framing error, then the receiver must recover for the next one
    ulss_serial_partner_i.send(8'h5A, 8, 1'b0, 1'b0, 1'b0);
    rd(ADDR_LINE_STATUS, 33'h69);
    rd(ADDR_RX_BUFFER, 33'h5A);
    rd(ADDR_LINE_STATUS, 33'h60);
    ulss_serial_partner_i.send(8'hC3, 8, 1'b0, 1'b0, 1'b1);
    rd(ADDR_RX_BUFFER, 33'hC3);
    // break: line low for twelve bits, longer than a ten bit frame
    ulss_serial_partner_i.hold(1'b0, 12);
    ulss_serial_partner_i.hold(1'b1, 2);
    @(negedge pclk) `CHK(int_id, INT_ID_LINE)
    rd(ADDR_LINE_STATUS, 33'h79);
    rd(ADDR_RX_BUFFER, 33'h00);
    rd(ADDR_LINE_STATUS, 33'h60);
    // let the monitor take the last read before closing
    repeat (2) @(posedge pclk);
    `CHK(exp_q.size(), 0)
    test_done();
  end
endmodule : uart_line_status_scratch_bench
`default_nettype wire
